// File: pwdc_pkg.sv
/*
 * shared constants for the power, wake-up and duty-cycle control block:
 * command codes, field positions, reset values and timing counts.
 * assumes a 20 MHz system clock.
 */
package pwdc_pkg;
    // ************************************************************
    // command decode
    // ************************************************************
    localparam logic [7:0] PMC_CODE = 8'h82;
    localparam logic [2:0] WTS_CODE = 3'h7;
    localparam logic [7:0] DCS_CODE = 8'hC8;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] PMC_RESET = 16'h8208;
    localparam logic [15:0] WTS_RESET = 16'hE196;
    localparam logic [15:0] DCS_RESET = 16'hC80E;
    // ************************************************************
    // power word bit positions
    // ************************************************************
    localparam int RX_BIT = 7;
    localparam int BB_BIT = 6;
    localparam int TX_BIT = 5;
    localparam int SYN_BIT = 4;
    localparam int OSC_BIT = 3;
    localparam int LBD_BIT = 2;
    localparam int WUT_BIT = 1;
    localparam int CLKO_BIT = 0;
    // wake-up word fields
    localparam int EXP_HI = 12;
    localparam int EXP_LO = 8;
    localparam int MUL_HI = 7;
    localparam int MUL_LO = 0;
    // duty word fields
    localparam int DUTY_HI = 7;
    localparam int DUTY_LO = 1;
    localparam int DUTY_EN_BIT = 0;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 20000000;
    // wake-up unit 1.03 ms and offset 0.5 ms, expressed in microseconds
    localparam int UNIT_US = 1030;
    localparam int OFFSET_US = 500;
    localparam int UNIT_CYC = UNIT_US * (CLK_HZ / 1000000);
    localparam int OFFSET_CYC = OFFSET_US * (CLK_HZ / 1000000);
    // receive on-time per step of (2*duty+1), taken as 1% of unit
    localparam int DUTY_STEP_CYC = UNIT_CYC / 100;
endpackage

// File: pwdc_counter.sv
/*
 * loadable down counter with a done pulse.
 * assumes load and enable from logic on the same clock.
 */
`timescale 1ns/100ps
module pwdc_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [55:0] value_i,
    input wire logic run_i,
    output logic done_o,
    output logic busy_o
);
    logic [55:0] count_reg;

    // count down while running, pulse done on reaching zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= 56'h0;
            done_o <= 1'b0;
        end else if (load_i) begin
            count_reg <= value_i;
            done_o <= 1'b0;
        end else if (run_i && count_reg != 56'h0) begin
            count_reg <= count_reg - 56'h1;
            done_o <= (count_reg == 56'h1);
        end else begin
            done_o <= 1'b0;
        end
    end

    assign busy_o = (count_reg != 56'h0);
endmodule

// File: pwdc_top.sv
/*
 * power management, wake-up timer and duty-cycle control.
 * takes 16-bit commands from a serial peripheral link (sck, sdi, cs_n)
 * and drives power-control enables. assumes the link pins are async
 * to clk_i and are synchronised here.
 */
// Behaviour
// - upper byte 0x82 writes low byte into power word.
// - top three bits 111 load lower thirteen bits into wake-up word.
// - upper byte 0xC8 writes low byte into duty word.
// - bit 7 enables receive chain with baseband, synthesizer, oscillator.
// - bit 5 enables transmit chain and transmission when register enabled.
// - bit 4 enables synthesizer.
// - bit 3 enables crystal oscillator, except clock-output override.
// - bit 2 enables battery detector.
// - bit 1 enables wake-up timer.
// - bit 0 low drives clock output, high stops it.
// - clock output enabled keeps oscillator running, no full sleep.
// - reset loads power word 0x8208, clock output enabled.
// - wake-up multiplier is bits 7 to 0, 0 to 255.
// - interval equals 1.03 ms times multiplier times 2^exp plus 0.5 ms.
// - duty bits 7 to 1 set receiver on-time after wake-up.
// - duty bit 0 enables duty-cycle mode.
// - each wake-up in duty mode powers receiver briefly then sleeps.
// - duty cycle is (2*duty+1)/multiplier percent.
// - commands are ignored while in reset.
`timescale 1ns/100ps
module pwdc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic cs_n_i,
    input wire logic tx_reg_enable_i,
    output logic receive_chain_enable_o,
    output logic baseband_enable_o,
    output logic transmit_chain_enable_o,
    output logic transmit_start_o,
    output logic synthesizer_enable_o,
    output logic oscillator_enable_o,
    output logic battery_detector_enable_o,
    output logic wakeup_timer_enable_o,
    output logic clock_output_enable_o,
    output logic full_sleep_o,
    output logic wakeup_event_o,
    output logic [15:0] power_management_config_o,
    output logic [15:0] wakeup_timer_setting_o,
    output logic [15:0] duty_cycle_setting_o
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic sck_d_reg;

    // two stages before any logic looks at the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 3'h4;
            sync2_reg <= 3'h4;
            sck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {cs_n_i, sck_i, sdi_i};
            sync2_reg <= sync1_reg;
            sck_d_reg <= sync2_reg[1];
        end
    end

    logic cs_n_s;
    logic sck_s;
    logic sdi_s;
    logic sck_rise;
    assign cs_n_s = sync2_reg[2];
    assign sck_s = sync2_reg[1];
    assign sdi_s = sync2_reg[0];
    assign sck_rise = sck_s & ~sck_d_reg;

    // ************************************************************
    // command shifter
    // ************************************************************
    logic [15:0] shift_reg;
    logic [4:0] bits_reg;
    logic word_ready_reg;

    // shift msb first; a frame cut short leaves bits_reg below 16
    always_ff @(posedge clk_i) begin
        if (rst_i || cs_n_s) begin
            shift_reg <= 16'h0;
            bits_reg <= 5'h0;
            word_ready_reg <= 1'b0;
        end else begin
            word_ready_reg <= 1'b0;
            if (sck_rise && bits_reg < 5'h10) begin
                shift_reg <= {shift_reg[14:0], sdi_s};
                bits_reg <= bits_reg + 5'h1;
                word_ready_reg <= (bits_reg == 5'hF);
            end
        end
    end

    // ************************************************************
    // configuration words
    // ************************************************************
    logic [15:0] pmc_reg;
    logic [15:0] wts_reg;
    logic [15:0] dcs_reg;
    logic pmc_wr;
    logic wts_wr;
    logic dcs_wr;

    assign pmc_wr = word_ready_reg && shift_reg[15:8] == pwdc_pkg::PMC_CODE;
    assign wts_wr = word_ready_reg &&
        shift_reg[15:13] == pwdc_pkg::WTS_CODE;
    assign dcs_wr = word_ready_reg && shift_reg[15:8] == pwdc_pkg::DCS_CODE;

    // power word, default keeps the clock output running for the host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pmc_reg <= pwdc_pkg::PMC_RESET;
        end else if (pmc_wr) begin
            pmc_reg <= {pwdc_pkg::PMC_CODE, shift_reg[7:0]};
        end
    end

    // wake-up word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wts_reg <= pwdc_pkg::WTS_RESET;
        end else if (wts_wr) begin
            wts_reg <= {pwdc_pkg::WTS_CODE, shift_reg[12:0]};
        end
    end

    // duty word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcs_reg <= pwdc_pkg::DCS_RESET;
        end else if (dcs_wr) begin
            dcs_reg <= {pwdc_pkg::DCS_CODE, shift_reg[7:0]};
        end
    end

    logic rx_en;
    logic wut_en;
    logic clko_n;
    logic [4:0] wakeup_exponent;
    logic [7:0] wakeup_multiplier;
    logic [6:0] duty_multiplier;
    logic duty_mode_enable;
    assign rx_en = pmc_reg[pwdc_pkg::RX_BIT];
    assign wut_en = pmc_reg[pwdc_pkg::WUT_BIT];
    assign clko_n = pmc_reg[pwdc_pkg::CLKO_BIT];
    assign wakeup_exponent = wts_reg[pwdc_pkg::EXP_HI:pwdc_pkg::EXP_LO];
    assign wakeup_multiplier = wts_reg[pwdc_pkg::MUL_HI:pwdc_pkg::MUL_LO];
    assign duty_multiplier = dcs_reg[pwdc_pkg::DUTY_HI:pwdc_pkg::DUTY_LO];
    assign duty_mode_enable = dcs_reg[pwdc_pkg::DUTY_EN_BIT];

    // ************************************************************
    // wake-up timer and duty cycle
    // ************************************************************
    // 56 bits: 255 units shifted by 29 need 52, 48 would wrap
    localparam logic [55:0] UNIT = 56'(pwdc_pkg::UNIT_CYC);
    localparam logic [55:0] OFFSET = 56'(pwdc_pkg::OFFSET_CYC);
    localparam logic [55:0] STEP = 56'(pwdc_pkg::DUTY_STEP_CYC);

    logic wut_en_d_reg;
    logic arm;
    logic wake_done;
    logic wake_busy;
    logic [55:0] interval;

    // exponent above 29 is the host's fault; shift still bounded
    assign interval = ((UNIT * 56'(wakeup_multiplier)) <<
        wakeup_exponent) + OFFSET;
    assign arm = wut_en & ~wut_en_d_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wut_en_d_reg <= 1'b0;
        end else begin
            wut_en_d_reg <= wut_en;
        end
    end

    // one shot per arming: timer must be re-enabled each cycle
    pwdc_counter u_wake (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(arm),
        .value_i(interval),
        .run_i(wut_en),
        .done_o(wake_done),
        .busy_o(wake_busy)
    );

    logic [31:0] duty_cnt_reg;
    logic duty_rx_reg;
    logic [31:0] on_time;
    assign on_time = 32'((56'({duty_multiplier, 1'b1})) * STEP);

    // receiver burst after each wake-up while duty mode is on
    always_ff @(posedge clk_i) begin
        if (rst_i || !duty_mode_enable || !wut_en) begin
            duty_cnt_reg <= 32'h0;
            duty_rx_reg <= 1'b0;
        end else if (wake_done) begin
            duty_cnt_reg <= on_time;
            duty_rx_reg <= 1'b1;
        end else if (duty_cnt_reg > 32'h1) begin
            duty_cnt_reg <= duty_cnt_reg - 32'h1;
        end else begin
            duty_cnt_reg <= 32'h0;
            duty_rx_reg <= 1'b0; // back to sleep
        end
    end

    // ************************************************************
    // power-control outputs
    // ************************************************************
    logic rx_on;
    logic osc_on;
    assign rx_on = rx_en | duty_rx_reg;
    // clock output forces the crystal on
    assign osc_on = pmc_reg[pwdc_pkg::OSC_BIT] | rx_on |
        pmc_reg[pwdc_pkg::SYN_BIT] | pmc_reg[pwdc_pkg::TX_BIT] |
        ~clko_n;

    // registered copies, one cycle after the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_chain_enable_o <= 1'b0;
            baseband_enable_o <= 1'b0;
            transmit_chain_enable_o <= 1'b0;
            transmit_start_o <= 1'b0;
            synthesizer_enable_o <= 1'b0;
            oscillator_enable_o <= 1'b1;
            battery_detector_enable_o <= 1'b0;
            wakeup_timer_enable_o <= 1'b0;
            clock_output_enable_o <= 1'b1;
            full_sleep_o <= 1'b0;
            wakeup_event_o <= 1'b0;
        end else begin
            receive_chain_enable_o <= rx_on;
            baseband_enable_o <= pmc_reg[pwdc_pkg::BB_BIT] | rx_on;
            transmit_chain_enable_o <= pmc_reg[pwdc_pkg::TX_BIT];
            transmit_start_o <= pmc_reg[pwdc_pkg::TX_BIT] &
                tx_reg_enable_i;
            synthesizer_enable_o <= pmc_reg[pwdc_pkg::SYN_BIT] |
                rx_on | pmc_reg[pwdc_pkg::TX_BIT];
            oscillator_enable_o <= osc_on;
            battery_detector_enable_o <= pmc_reg[pwdc_pkg::LBD_BIT];
            wakeup_timer_enable_o <= wut_en;
            clock_output_enable_o <= ~clko_n;
            full_sleep_o <= ~osc_on & ~pmc_reg[pwdc_pkg::LBD_BIT] &
                ~(wut_en & wake_busy);
            wakeup_event_o <= wake_done;
        end
    end

    // readback copies of the stored words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_management_config_o <= pwdc_pkg::PMC_RESET;
            wakeup_timer_setting_o <= pwdc_pkg::WTS_RESET;
            duty_cycle_setting_o <= pwdc_pkg::DCS_RESET;
        end else begin
            power_management_config_o <= pmc_reg;
            wakeup_timer_setting_o <= wts_reg;
            duty_cycle_setting_o <= dcs_reg;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // write, hold and framing of the three words
    a_pmc_write: assert property (@(posedge clk_i)
        disable iff (rst_i) pmc_wr |=> pmc_reg[7:0] == $past(shift_reg[7:0]))
        else $error("power word not written");
    a_wts_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wts_wr |=> wts_reg[12:0] == $past(shift_reg[12:0]))
        else $error("wake-up word not written");
    a_dcs_write: assert property (@(posedge clk_i)
        disable iff (rst_i) dcs_wr |=> dcs_reg[7:0] == $past(shift_reg[7:0]))
        else $error("duty word not written");
    a_pmc_hold: assert property (@(posedge clk_i)
        disable iff (rst_i) !pmc_wr |=> $stable(pmc_reg))
        else $error("power word changed without command");
    a_wts_hold: assert property (@(posedge clk_i)
        disable iff (rst_i) !wts_wr |=> $stable(wts_reg))
        else $error("wake-up word changed without command");
    a_dcs_hold: assert property (@(posedge clk_i)
        disable iff (rst_i) !dcs_wr |=> $stable(dcs_reg))
        else $error("duty word changed without command");
    a_word_len: assert property (@(posedge clk_i)
        disable iff (rst_i) word_ready_reg |-> bits_reg == 5'h10)
        else $error("word taken before sixteen bits");
    a_reset_drop: assert property (@(posedge clk_i)
        rst_i |=> !word_ready_reg)
        else $error("command taken during reset");
    a_reset_pmc: assert property (@(posedge clk_i)
        rst_i |=> pmc_reg == pwdc_pkg::PMC_RESET)
        else $error("power word reset value wrong");
    // each enable follows its stored bit one edge later
    a_rx_follow: assert property (@(posedge clk_i)
        disable iff (rst_i) rx_en |=> receive_chain_enable_o)
        else $error("receive chain not enabled");
    a_clko_osc: assert property (@(posedge clk_i)
        disable iff (rst_i) !clko_n |=> oscillator_enable_o &&
        clock_output_enable_o && !full_sleep_o)
        else $error("oscillator stopped with clock output on");
    a_clko_stop: assert property (@(posedge clk_i)
        disable iff (rst_i) clko_n |=> !clock_output_enable_o)
        else $error("clock output not stopped");
    a_tx_start: assert property (@(posedge clk_i)
        disable iff (rst_i) transmit_start_o |-> transmit_chain_enable_o)
        else $error("transmit start without chain");
    a_tx_off: assert property (@(posedge clk_i)
        disable iff (rst_i) !pmc_reg[pwdc_pkg::TX_BIT] |=>
        !transmit_chain_enable_o && !transmit_start_o)
        else $error("transmit chain left on");
    a_syn_follow: assert property (@(posedge clk_i)
        disable iff (rst_i) pmc_reg[pwdc_pkg::SYN_BIT] |=>
        synthesizer_enable_o)
        else $error("synthesizer not enabled");
    a_osc_follow: assert property (@(posedge clk_i)
        disable iff (rst_i) pmc_reg[pwdc_pkg::OSC_BIT] |=>
        oscillator_enable_o)
        else $error("oscillator not enabled");
    a_lbd_follow: assert property (@(posedge clk_i)
        disable iff (rst_i) pmc_reg[pwdc_pkg::LBD_BIT] |=>
        battery_detector_enable_o == 1'b1)
        else $error("battery detector not enabled");
    a_wut_follow: assert property (@(posedge clk_i)
        disable iff (rst_i) wut_en |=> wakeup_timer_enable_o)
        else $error("wake-up timer not enabled");
    a_wake_arm: assert property (@(posedge clk_i)
        disable iff (rst_i) arm |=> wake_busy)
        else $error("wake-up timer not loaded");
    a_wake_pulse: assert property (@(posedge clk_i)
        disable iff (rst_i) wake_done |=> wakeup_event_o && !wake_done)
        else $error("wake-up event not a single pulse");
    a_duty_burst: assert property (@(posedge clk_i)
        disable iff (rst_i) wake_done && duty_mode_enable && wut_en |=>
        duty_rx_reg ##1 receive_chain_enable_o)
        else $error("no receive burst after wake-up");
    a_duty_idle: assert property (@(posedge clk_i)
        disable iff (rst_i) !duty_mode_enable |=> !duty_rx_reg)
        else $error("receive burst outside duty mode");
endmodule

// File: pwdc_host.sv
/*
 * host-side model: shifts 16-bit command words into the block over the
 * serial link, msb first, with chip select framing each word.
 * assumes tasks are called just after a falling edge of clk_i.
 */
`timescale 1ns/100ps
module pwdc_host (
    input wire logic clk_i,
    output logic sck_o,
    output logic sdi_o,
    output logic cs_n_o
);
    // ************************************************************
    // idle levels: link clock stands still between frames
    // ************************************************************
    initial begin
        sck_o = 1'b0;
        sdi_o = 1'b0;
        cs_n_o = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // ************************************************************
    // one frame of n bits; 4 clk per phase beats the 3 clk minimum
    // ************************************************************
    task automatic send(input logic [15:0] w, input int n);
        cs_n_o = 1'b0;
        hold(4);
        for (int i = 15; i > 15 - n; i--) begin
            sdi_o = w[i];
            hold(4);
            sck_o = 1'b1;
            hold(4);
            sck_o = 1'b0;
        end
        hold(4);
        cs_n_o = 1'b1; // frame closed, whole or partial
        sdi_o = ~sdi_o; // released line keeps no stale bit
        hold(4);
    endtask
endmodule

// File: power_wakeup_duty_control_test.sv
/*
 * self-checking bench: integer model of the three words compared with
 * every output but the wake-up event after each frame (full sleep only with timer bit clear), plus wake-up and duty burst timing.
 * assumes a 20 MHz clock and the host model in pwdc_host.
 */
`timescale 1ns/100ps
module power_wakeup_duty_control_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic tx_reg_enable_i = 1'b0;
    logic sck, sdi, cs_n;
    logic rx, bb, tx, ts, syn, osc, lbd, wut, clko, slp, wev;
    logic [15:0] pmo, wto, dco;
    int pm = 8'h08;
    int wt = 13'h0196;
    int dc = 8'h0E;
    int n_fail = 0;
    int total_checks = 0;

    // clock of 50 ns period
    always #25 clk_i = ~clk_i;

    pwdc_host host (.clk_i(clk_i), .sck_o(sck), .sdi_o(sdi),
        .cs_n_o(cs_n));

    pwdc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck),
        .sdi_i(sdi), .cs_n_i(cs_n), .tx_reg_enable_i(tx_reg_enable_i),
        .receive_chain_enable_o(rx), .baseband_enable_o(bb),
        .transmit_chain_enable_o(tx), .transmit_start_o(ts),
        .synthesizer_enable_o(syn), .oscillator_enable_o(osc),
        .battery_detector_enable_o(lbd), .wakeup_timer_enable_o(wut),
        .clock_output_enable_o(clko), .full_sleep_o(slp),
        .wakeup_event_o(wev), .power_management_config_o(pmo),
        .wakeup_timer_setting_o(wto), .duty_cycle_setting_o(dco));

    // ************************************************************
    // reporting
    // ************************************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            n_fail++;
            $display("[ERR] %0t wait ran out", $time);
            finish_test();
        end
    endtask

    // ************************************************************
    // model comparison of every static output
    // ************************************************************
    task automatic chk_all;
        logic [7:0] p;
        logic o;
        p = pm[7:0];
        // oscillator forced by any chain or by the clock output
        o = p[3] | p[7] | p[4] | p[5] | ~p[0];
        chk(pmo, {8'h82, p});
        chk(wto, {3'h7, wt[12:0]});
        chk(dco, {8'hC8, dc[7:0]});
        chk(16'({rx, bb}), 16'({p[7], p[6] | p[7]}));
        chk(16'({tx, ts}), 16'({p[5], p[5] & tx_reg_enable_i}));
        chk(16'({syn, osc}), 16'({p[4] | p[7] | p[5], o}));
        chk(16'({lbd, wut}), 16'({p[2], p[1]}));
        chk(16'(clko), 16'(!p[0]));
        if (p[1] == 1'b0) chk(16'(slp), 16'(!(o | p[2])));
    endtask

    task automatic wr(input logic [15:0] w);
        host.send(w, 16);
        if (w[15:8] == 8'h82) pm = w[7:0];
        else if (w[15:13] == 3'h7) wt = w[12:0];
        else if (w[15:8] == 8'hC8) dc = w[7:0];
        repeat (8) @(negedge clk_i);
        chk_all();
    endtask

    // bounded wait for the wake-up pulse, then compare its delay
    task automatic wait_wake(input int e);
        int n;
        n = 0;
        while (wev !== 1'b1 && n < 60000) begin
            @(negedge clk_i);
            n++;
        end
        bound(n, 60000);
        chk(16'(n > e - 8 && n < e + 8), 16'h1);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int n;
        int e;
        logic [15:0] q[$];
        void'($urandom(32'h9D21));
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk_all();
        // random words of every code, then an unknown code
        for (int i = 0; i < 8; i++) q.push_back({8'h82, 8'($urandom)});
        q.push_back(16'h8248);
        q.push_back({3'h7, 5'($urandom % 30), 8'($urandom)});
        q.push_back({8'hC8, 7'($urandom), 1'b0});
        q.push_back(16'hCA55);
        while (q.size() > 0) begin
            tx_reg_enable_i = 1'($urandom);
            wr(q.pop_front());
        end
        // short frame must be dropped
        host.send(16'h82FF, 12);
        repeat (8) @(negedge clk_i);
        chk_all();
        // reset released mid-frame: the remaining bits form a short frame
        rst_i = 1'b1;
        fork
            host.send(16'h82A5, 16);
            begin
                repeat (100) @(negedge clk_i);
                rst_i = 1'b0;
            end
        join
        pm = 8'h08;
        wt = 13'h0196;
        dc = 8'h0E;
        repeat (4) @(negedge clk_i);
        chk_all();
        // duty mode: multiplier 1, exponent 0, duty value 2
        wr(16'hE001);
        wr(16'hC805);
        wr(16'h8200);
        wr(16'h8202);
        // about 14 clk of the interval already elapsed inside wr
        wait_wake(20600 * 1 + 10000 - 14);
        n = 0;
        while (rx !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        bound(n, 20);
        chk(16'(bb), 16'h1);
        e = 0;
        while (rx === 1'b1 && e < 3000) begin
            @(negedge clk_i);
            e++;
        end
        chk(16'(e > 1026 && e < 1034), 16'h1);
        // exponent 1 doubles the multiplied part of the interval
        wr(16'hE101);
        wr(16'h8200);
        wr(16'h8202);
        wait_wake(20600 * 1 * 2 + 10000 - 14);
        finish_test();
    end
endmodule
